// *** logic/bvf_deglitch.sv ***
// Deglitch filter for the hardware current-limit lock detection
module bvf_deglitch import bvf_pkg::*; #(
	parameter int unsigned STEP_CYCLES = DEGLITCH_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Filter
	input  wire logic [2:0] code,
	input  wire logic       raw,
	output logic            qualified
);
	localparam int unsigned DIV_W = $clog2(STEP_CYCLES + 1);

	if (STEP_CYCLES < 2) begin : g_bad_step
		$error("STEP_CYCLES must be at least 2");
	end

	//==========================================================================
	// State: microsecond divider restarted by every low sample
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [2:0]       steps;
		logic             q;
		logic [9:0]       run;
	} bvf_deg_state_type;

	bvf_deg_state_type s;
	bvf_deg_state_type next_s;

	always_comb begin
		next_s = s;
		if (!raw) begin
			next_s.div   = '0;
			next_s.steps = 3'h0;
			next_s.run   = 10'h000;
		end else begin
			if (s.run != 10'h3FF) begin
				next_s.run = s.run + 10'h001;
			end
			if (s.div == DIV_W'(STEP_CYCLES - 1)) begin
				next_s.div = '0;
				if (s.steps != 3'h7) begin
					next_s.steps = s.steps + 3'h1;
				end
			end else begin
				next_s.div = s.div + DIV_W'(1);
			end
		end
		// Code zero passes the level with one register of delay
		next_s.q = raw && ((code == 3'h0) || (next_s.steps >= code));
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign qualified = s.q;

	//==========================================================================
	// Checks; run counts held-high samples and is read only here
	a_deg_bypass: assert property (@(posedge ref_clk) disable iff (!rstn)
		code == 3'h0 && raw |=> qualified) else $error("no-deglitch code delayed lock");
	a_deg_minimum: assert property (@(posedge ref_clk) disable iff (!rstn)
		qualified |-> (int'(s.run) >= int'(code) * int'(STEP_CYCLES)))
		else $error("lock qualified before deglitch time");
endmodule

// *** logic/bvf_fault_ctrl.sv ***
// Bus voltage fault supervisor and current-limit lock retry controller with APB registers
//
// Register access over APB and the register addresses were chosen for this implementation.
module bvf_fault_ctrl import bvf_pkg::*; #(
	parameter int unsigned RETRY_WAIT_CYCLES = RETRY_WAIT_DEFAULT
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Sensing
	input  wire bvf_volt_type      bus_voltage,
	input  wire logic              lock_detect,
	// Fault outputs
	output logic                   uv_fault,
	output logic                   ov_fault,
	output logic                   lock_fault,
	output logic                   fault_indicator_n,
	output logic                   irq
);
	localparam int unsigned WAIT_W = $clog2(RETRY_WAIT_CYCLES);

	if (RETRY_WAIT_CYCLES < 2) begin : g_bad_wait
		$error("RETRY_WAIT_CYCLES must be at least 2");
	end

	//==========================================================================
	// State
	typedef struct packed {
		logic [31:0]        cfg;
		logic [3:0]         irq_status;
		logic [3:0]         irq_enable;
		bvf_lock_state_type lock_state;
		logic [4:0]         retry_count;
		logic [WAIT_W-1:0]  wait_cnt;
		logic               perm;
		logic               uv_prev;
		logic               ov_prev;
		logic               lock_fault;
		logic               pready;
		logic               pslverr;
		logic [31:0]        prdata;
		logic               fault_n;
		logic               irq;
	} bvf_ctrl_state_type;

	bvf_ctrl_state_type s;
	bvf_ctrl_state_type next_s;

	bvf_mon_if uv_if ();
	bvf_mon_if ov_if ();

	logic       wr_fire;
	logic [3:0] fault_clr;
	logic       lock_q;
	logic [2:0] action;
	logic       auto_mode;
	logic [4:0] limit;

	// Byte-lane merge for the configuration register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = wd[8*i +: 8];
			end
		end
	endfunction

	//==========================================================================
	// Write strobe and fault clear pulses
	assign wr_fire   = psel && penable && s.pready && pwrite;
	assign fault_clr = (wr_fire && paddr == ADDR_FAULT_CLEAR && pstrb[0]) ? pwdata[3:0] : 4'h0;

	// Configuration decode
	assign action    = s.cfg[ACTION_LSB +: 3];
	assign auto_mode = (action >= ACT_RETRY_TRI) && (action <= ACT_RETRY_HIGH);
	assign limit     = retry_limit(s.cfg[RETRY_LSB +: 3]);

	// Undervoltage monitor wiring
	assign uv_if.voltage    = bus_voltage;
	assign uv_if.threshold  = uv_level(s.cfg[UV_LSB +: 3]);
	assign uv_if.hysteresis = hyst_level(s.cfg[HYST_LSB +: 2]);
	assign uv_if.enable     = s.cfg[UV_LSB +: 3] != 3'h0;
	assign uv_if.auto_clear = s.cfg[UV_MODE_BIT];
	assign uv_if.sw_clear   = fault_clr[BIT_UV];

	// Overvoltage monitor wiring, same hysteresis
	assign ov_if.voltage    = bus_voltage;
	assign ov_if.threshold  = ov_level(s.cfg[OV_LSB +: 3]);
	assign ov_if.hysteresis = hyst_level(s.cfg[HYST_LSB +: 2]);
	assign ov_if.enable     = s.cfg[OV_LSB +: 3] != 3'h0;
	assign ov_if.auto_clear = s.cfg[OV_MODE_BIT];
	assign ov_if.sw_clear   = fault_clr[BIT_OV];

	bvf_volt_mon #(.OVER(1'b0)) u_uv_mon (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.mon     (uv_if.mon)
	);

	bvf_volt_mon #(.OVER(1'b1)) u_ov_mon (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.mon     (ov_if.mon)
	);

	bvf_deglitch #(.STEP_CYCLES(DEGLITCH_STEP_CYCLES)) u_deglitch (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.code      (s.cfg[DEG_LSB +: 3]),
		.raw       (lock_detect),
		.qualified (lock_q)
	);

	//==========================================================================
	// Next state
	always_comb begin
		logic [3:0] irq_set;
		irq_set = 4'h0;
		next_s  = s;

		// Answer prepared in the setup cycle so every bus output is a flop
		next_s.pready = 1'b0;
		if (psel && !penable) begin
			next_s.pready  = 1'b1;
			next_s.pslverr = !addr_mapped(paddr);
			unique case (paddr)
				ADDR_CONFIG:     next_s.prdata = s.cfg;
				ADDR_STATUS:     next_s.prdata = {23'h000000, s.retry_count, s.perm,
					s.lock_fault, ov_if.fault, uv_if.fault};
				ADDR_IRQ_STATUS: next_s.prdata = {28'h0000000, s.irq_status};
				ADDR_IRQ_ENABLE: next_s.prdata = {28'h0000000, s.irq_enable};
				default:         next_s.prdata = 32'h0000_0000;
			endcase
		end

		// Register writes take effect at the end of the access phase
		if (wr_fire) begin
			unique case (paddr)
				ADDR_CONFIG:     next_s.cfg = merge(s.cfg, pwdata, pstrb);
				ADDR_IRQ_ENABLE: next_s.irq_enable = pstrb[0] ? pwdata[3:0] : s.irq_enable;
				default:         next_s.cfg = s.cfg;
			endcase
		end

		// Lock retry sequencer; a new lock event outranks a software clear
		unique case (s.lock_state)
			LK_IDLE: begin
				if (lock_q && action != ACT_DISABLED) begin
					irq_set[BIT_LOCK] = 1'b1;
					if (auto_mode && (limit == 5'h00 || s.retry_count < limit)) begin
						next_s.lock_state = LK_WAIT;
						next_s.wait_cnt   = '0;
					end else begin
						next_s.lock_state = LK_LATCHED;
						if (auto_mode) begin
							next_s.perm       = 1'b1;
							irq_set[BIT_PERM] = 1'b1;
						end
					end
				end else if (fault_clr[BIT_LOCK]) begin
					next_s.retry_count = 5'h00;
				end
			end
			LK_WAIT: begin
				if (fault_clr[BIT_LOCK]) begin
					next_s.lock_state  = LK_IDLE;
					next_s.retry_count = 5'h00;
				end else if (s.wait_cnt == WAIT_W'(RETRY_WAIT_CYCLES - 1)) begin
					next_s.lock_state = LK_IDLE;
					if (s.retry_count != 5'h1F) begin
						next_s.retry_count = s.retry_count + 5'h01;
					end
				end else begin
					next_s.wait_cnt = s.wait_cnt + WAIT_W'(1);
				end
			end
			LK_LATCHED: begin
				if (fault_clr[BIT_LOCK]) begin
					next_s.lock_state  = LK_IDLE;
					next_s.perm        = 1'b0;
					next_s.retry_count = 5'h00;
				end
			end
			default: next_s.lock_state = LK_IDLE;
		endcase
		next_s.lock_fault = next_s.lock_state != LK_IDLE;

		// Sticky events; a set in the cycle of its clear survives
		irq_set[BIT_UV] = uv_if.fault && !s.uv_prev;
		irq_set[BIT_OV] = ov_if.fault && !s.ov_prev;
		next_s.uv_prev  = uv_if.fault;
		next_s.ov_prev  = ov_if.fault;
		if (wr_fire && paddr == ADDR_IRQ_CLEAR && pstrb[0]) begin
			next_s.irq_status = s.irq_status & ~pwdata[3:0];
		end
		next_s.irq_status = next_s.irq_status | irq_set;
		next_s.irq        = |(next_s.irq_status & next_s.irq_enable);
		next_s.fault_n    = !(uv_if.fault || ov_if.fault || s.lock_fault);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s            <= '0;
			s.cfg        <= CONFIG_RESET;
			s.irq_enable <= IRQ_ENABLE_RESET;
			s.lock_state <= LK_IDLE;
			s.fault_n    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs
	assign pready            = s.pready;
	assign prdata            = s.prdata;
	assign pslverr           = s.pslverr;
	assign uv_fault          = uv_if.fault;
	assign ov_fault          = ov_if.fault;
	assign lock_fault        = s.lock_fault;
	assign fault_indicator_n = s.fault_n;
	assign irq               = s.irq;

	//==========================================================================
	// Checks
	sequence s_lock_over_limit;
		s.lock_state == LK_IDLE && lock_q && auto_mode && limit != 5'h00 &&
			s.retry_count >= limit;
	endsequence

	sequence s_cfg_access;
		psel && !penable && pwrite && paddr == ADDR_CONFIG && pstrb == 4'hF
			##1 psel && penable && $stable(pwdata);
	endsequence

	a_retry_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_lock_over_limit |=> s.lock_state == LK_LATCHED && s.perm ##1 lock_fault)
		else $error("retry limit exceeded without permanent latch");
	a_retry_allowed: assert property (@(posedge ref_clk) disable iff (!rstn)
		s.lock_state == LK_IDLE && lock_q && auto_mode && s.retry_count < limit
		|=> s.lock_state == LK_WAIT) else $error("retry refused below limit");
	a_cfg_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_cfg_access |=> s.cfg == $past(pwdata)) else $error("configuration write lost");
	a_lock_latched: assert property (@(posedge ref_clk) disable iff (!rstn)
		s.lock_state == LK_LATCHED && !fault_clr[BIT_LOCK] |=> s.lock_state == LK_LATCHED)
		else $error("latched lock fault dropped without clear");
	a_fault_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
		uv_if.fault |=> !fault_indicator_n) else $error("fault indicator not asserted");
endmodule

// *** logic/bvf_mon_if.sv ***
// Interface between the fault controller and one bus voltage monitor
interface bvf_mon_if;
	import bvf_pkg::*;
	bvf_volt_type voltage;
	bvf_volt_type threshold;
	bvf_volt_type hysteresis;
	logic         enable;
	logic         auto_clear;
	logic         sw_clear;
	logic         fault;

	modport mon (input voltage, threshold, hysteresis, enable, auto_clear, sw_clear,
		output fault);
	modport ctl (output voltage, threshold, hysteresis, enable, auto_clear, sw_clear,
		input fault);
endinterface

// *** logic/bvf_pkg.sv ***
// Package of constants, types and decode functions for the bus voltage fault block
//==========================================================================
// Operation
// - Lock detection deglitched zero to seven microseconds
// - One hysteresis value shared by both faults
// - Trip at threshold, clear beyond hysteresis
// - Undervoltage threshold code, zero means no limit
// - Undervoltage fault latched or automatically cleared
// - Overvoltage threshold code, zero means no limit
// - Overvoltage fault latched or automatically cleared
// - Retry attempts limited by code, zero unlimited
// - Retry modes latch once retries exceed limit
package bvf_pkg;
	//==========================================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS        = 25;
	localparam int unsigned DEGLITCH_STEP_NS     = 1000;
	localparam int unsigned DEGLITCH_STEP_CYCLES =
		(DEGLITCH_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RETRY_WAIT_DEFAULT   = 40000;

	//==========================================================================
	// Register offsets, byte addresses
	localparam int unsigned ADDR_W           = 8;
	localparam logic [7:0]  ADDR_CONFIG      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS      = 8'h04;
	localparam logic [7:0]  ADDR_FAULT_CLEAR = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_CLEAR   = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'h14;
	localparam logic [31:0] CONFIG_RESET     = 32'h0000_0000;
	localparam logic [3:0]  IRQ_ENABLE_RESET = 4'h0;

	//==========================================================================
	// Configuration field positions
	localparam int unsigned DEG_LSB     = 13;
	localparam int unsigned HYST_LSB    = 11;
	localparam int unsigned UV_LSB      = 8;
	localparam int unsigned UV_MODE_BIT = 7;
	localparam int unsigned OV_LSB      = 4;
	localparam int unsigned OV_MODE_BIT = 3;
	localparam int unsigned RETRY_LSB   = 0;
	localparam int unsigned ACTION_LSB  = 16;

	// Status, clear and interrupt bit positions
	localparam int unsigned BIT_UV        = 0;
	localparam int unsigned BIT_OV        = 1;
	localparam int unsigned BIT_LOCK      = 2;
	localparam int unsigned BIT_PERM      = 3;
	localparam int unsigned ST_RETRY_LSB  = 4;

	// Lock action codes that matter here
	localparam logic [2:0] ACT_RETRY_TRI  = 3'h3;
	localparam logic [2:0] ACT_RETRY_HIGH = 3'h5;
	localparam logic [2:0] ACT_DISABLED   = 3'h7;

	//==========================================================================
	// Types; voltages are in units of 100 mV
	typedef logic [11:0] bvf_volt_type;
	typedef enum logic [2:0] {
		LK_IDLE    = 3'b001,
		LK_WAIT    = 3'b010,
		LK_LATCHED = 3'b100
	} bvf_lock_state_type;

	//==========================================================================
	// Decode functions
	function automatic bvf_volt_type uv_level(input logic [2:0] code);
		unique case (code)
			3'h1: uv_level = 12'h03C;
			3'h2: uv_level = 12'h046;
			3'h3: uv_level = 12'h050;
			3'h4: uv_level = 12'h064;
			3'h5: uv_level = 12'h08C;
			3'h6: uv_level = 12'h0A0;
			3'h7: uv_level = 12'h0B4;
			3'h0: uv_level = 12'h000;
		endcase
	endfunction

	function automatic bvf_volt_type ov_level(input logic [2:0] code);
		unique case (code)
			3'h1: ov_level = 12'h0B4;
			3'h2: ov_level = 12'h0C8;
			3'h3: ov_level = 12'h0DC;
			3'h4: ov_level = 12'h118;
			3'h5: ov_level = 12'h12C;
			3'h6: ov_level = 12'h140;
			3'h7: ov_level = 12'h154;
			3'h0: ov_level = 12'h000;
		endcase
	endfunction

	function automatic bvf_volt_type hyst_level(input logic [1:0] code);
		unique case (code)
			2'h0: hyst_level = 12'h005;
			2'h1: hyst_level = 12'h00A;
			2'h2: hyst_level = 12'h014;
			2'h3: hyst_level = 12'h01E;
		endcase
	endfunction

	// Zero means unlimited
	function automatic logic [4:0] retry_limit(input logic [2:0] code);
		unique case (code)
			3'h0: retry_limit = 5'h00;
			3'h1: retry_limit = 5'h02;
			3'h2: retry_limit = 5'h03;
			3'h3: retry_limit = 5'h05;
			3'h4: retry_limit = 5'h07;
			3'h5: retry_limit = 5'h0A;
			3'h6: retry_limit = 5'h0F;
			3'h7: retry_limit = 5'h14;
		endcase
	endfunction

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == ADDR_CONFIG) || (a == ADDR_STATUS) || (a == ADDR_FAULT_CLEAR) ||
			(a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE);
	endfunction
endpackage

// *** logic/bvf_volt_mon.sv ***
// Bus voltage monitor with hysteresis and latched or automatic recovery
module bvf_volt_mon import bvf_pkg::*; #(
	parameter bit OVER = 1'b0
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Controller side
	bvf_mon_if.mon    mon
);
	//==========================================================================
	// State
	typedef struct packed {
		logic fault;
	} bvf_mon_state_type;

	bvf_mon_state_type s;
	bvf_mon_state_type next_s;
	logic              trip;
	logic              back;

	// Trip on reaching the threshold, recover automatically only past the hysteresis band; a software clear needs no band
	assign trip = OVER ? (mon.voltage >= mon.threshold) : (mon.voltage <= mon.threshold);
	assign back = OVER ? (mon.voltage < mon.threshold - mon.hysteresis)
		: (mon.voltage > mon.threshold + mon.hysteresis);

	// Set wins over automatic and software clears; only a disabled limit drops a persisting fault
	always_comb begin
		next_s = s;
		if (!mon.enable) begin
			next_s.fault = 1'b0;
		end else if (trip) begin
			next_s.fault = 1'b1;
		end else if (mon.auto_clear && back) begin
			next_s.fault = 1'b0;
		end else if (mon.sw_clear) begin
			next_s.fault = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign mon.fault = s.fault;

	//==========================================================================
	// Checks
	a_trip_sets_fault: assert property (@(posedge ref_clk) disable iff (!rstn)
		mon.enable && trip |=> mon.fault) else $error("fault not raised at threshold");
	a_no_limit_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		!mon.enable |=> !mon.fault) else $error("fault raised with no limit");
	a_latch_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
		mon.enable && mon.fault && !mon.auto_clear && !mon.sw_clear |=> mon.fault)
		else $error("latched fault dropped without clear");
	a_band_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
		mon.enable && mon.fault && !back && !mon.sw_clear |=> mon.fault)
		else $error("fault cleared inside hysteresis band");
	a_auto_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
		mon.enable && mon.fault && mon.auto_clear && back && !trip |=> !mon.fault)
		else $error("automatic recovery missed");
endmodule

// *** sim/tb_bvf_fault_ctrl.sv ***
// Self-checking testbench for the bus voltage fault supervisor
module tb_bvf_fault_ctrl import bvf_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	//==========================================================================
	// Signals and tables, voltages in 100 mV units
	logic              ref_clk     = 1'b0;
	logic              rstn        = 1'b0;
	logic              psel        = 1'b0;
	logic              penable     = 1'b0;
	logic              pwrite      = 1'b0;
	logic [ADDR_W-1:0] paddr       = 8'h00;
	logic [31:0]       pwdata      = 32'h0000_0000;
	logic [3:0]        pstrb       = 4'hF;
	logic              pready;
	logic [31:0]       prdata;
	logic              pslverr;
	bvf_volt_type      bus_voltage = 12'h078;
	logic              lock_detect = 1'b0;
	logic              uv_fault;
	logic              ov_fault;
	logic              lock_fault;
	logic              fault_indicator_n;
	logic              irq;
	int                mismatches  = 0;
	int                comparisons = 0;
	logic [31:0]       rd;
	logic              err;
	localparam int UV_THR [8]  = '{0, 60, 70, 80, 100, 140, 160, 180};
	localparam int OV_THR [8]  = '{0, 180, 200, 220, 280, 300, 320, 340};
	localparam int HYST [4]    = '{5, 10, 20, 30};
	localparam int RETRIES [8] = '{0, 2, 3, 5, 7, 10, 15, 20};

	// Short retry wait keeps twenty retries within a few hundred cycles
	bvf_fault_ctrl #(.RETRY_WAIT_CYCLES(8)) bvf_fault_ctrl_inst (
		.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.bus_voltage(bus_voltage), .lock_detect(lock_detect),
		.uv_fault(uv_fault), .ov_fault(ov_fault), .lock_fault(lock_fault),
		.fault_indicator_n(fault_indicator_n), .irq(irq)
	);

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	//==========================================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the access ends at the rising edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		check(32'(n < 16), 32'h0000_0001);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Wait whole cycles, then settle mid-cycle
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic drive_v(input int v, input int n);
		@(posedge ref_clk);
		bus_voltage <= bvf_volt_type'(v);
		cyc(n);
	endtask

	//==========================================================================
	// Scenarios
	// Reset values, read-only status, unmapped address
	task automatic test_regs();
		check(fault_indicator_n, 1'b1);
		check(irq, 1'b0);
		apb(1'b0, ADDR_CONFIG, 32'h0);
		check(rd, CONFIG_RESET);
		apb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
		check(rd, 32'(IRQ_ENABLE_RESET));
		apb(1'b1, ADDR_CONFIG, 32'hA5A5_0000);
		apb(1'b0, ADDR_CONFIG, 32'h0);
		check(rd, 32'hA5A5_0000);
		apb(1'b1, ADDR_STATUS, 32'h0000_00FF);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(rd, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0000_0000);
		apb(1'b1, ADDR_CONFIG, 32'h0);
	endtask

	// Every nonzero threshold code: trip at it, hold in the band, clear just past it
	task automatic test_volt(input bit over);
		int thr, hv, s, off, exp;
		for (int c = 1; c < 8; c++) begin
			hv  = HYST[c % 4];
			thr = over ? OV_THR[c] : UV_THR[c];
			s   = over ? -1 : 1;
			drive_v(over ? 100 : 250, 2);
			apb(1'b1, ADDR_CONFIG, 32'(((c % 4) << 11) | (over ? (c << 4) | 8 : (c << 8) | 128)));
			for (int j = 0; j < 4; j++) begin
				off = (j == 0) ? 1 : (j == 1) ? 0 : (j == 2) ? hv : hv + 1;
				exp = (j == 1 || j == 2);
				drive_v(thr + s * off, 3);
				check(over ? ov_fault : uv_fault, 32'(exp));
				check(over ? uv_fault : ov_fault, 1'b0);
				check(fault_indicator_n, 32'(!exp));
			end
		end
	endtask

	// Latched faults outlive the voltage; interrupt raised, masked, cleared
	task automatic test_latch();
		for (int k = 0; k < 2; k++) begin
			drive_v(120, 2);
			apb(1'b1, ADDR_CONFIG, k ? 32'h0000_0010 : 32'h0000_0300);
			apb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_000F);
			apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_000F);
			drive_v(k ? 180 : 80, 3);
			check(irq, 1'b1);
			drive_v(120, 30);
			check(k ? ov_fault : uv_fault, 1'b1);
			check(fault_indicator_n, 1'b0);
			apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
			check(rd, 32'(1 << k));
			apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
			cyc(2);
			check(irq, 1'b0);
			apb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_000F);
			apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
			check(rd, 32'h0);
			apb(1'b1, ADDR_FAULT_CLEAR, 32'(1 << k));
			cyc(3);
			check({uv_fault, ov_fault, fault_indicator_n}, 3'b001);
		end
	endtask

	// Each deglitch code: a long pulse latches; for nonzero codes a pulse one sample short is ignored
	task automatic test_deglitch();
		int n;
		for (int c = 0; c < 8; c++) begin
			n = c * 40;
			apb(1'b1, ADDR_CONFIG, 32'(c << 13));
			if (n > 0) begin
				@(posedge ref_clk);
				lock_detect <= 1'b1;
				repeat (n - 1) @(posedge ref_clk);
				lock_detect <= 1'b0;
				cyc(4);
				check(lock_fault, 1'b0);
			end
			@(posedge ref_clk);
			lock_detect <= 1'b1;
			if (n > 2) begin
				cyc(n - 2);
				check(lock_fault, 1'b0);
			end
			cyc(6);
			check(lock_fault, 1'b1);
			@(posedge ref_clk);
			lock_detect <= 1'b0;
			apb(1'b1, ADDR_FAULT_CLEAR, 32'h0000_0004);
			cyc(3);
			check(lock_fault, 1'b0);
		end
	endtask

	// Each retry code under a lock that never goes away
	task automatic test_retry();
		int lim;
		apb(1'b1, ADDR_CONFIG, {13'h0, ACT_DISABLED, 16'h0000});
		lock_detect <= 1'b1;
		cyc(10);
		check(lock_fault, 1'b0);
		for (int c = 0; c < 8; c++) begin
			lim = RETRIES[c];
			@(posedge ref_clk);
			lock_detect <= 1'b0;
			apb(1'b1, ADDR_CONFIG, 32'(((3 + c % 3) << 16) | c));
			apb(1'b1, ADDR_FAULT_CLEAR, 32'h0000_0004);
			lock_detect <= 1'b1;
			cyc(400);
			apb(1'b0, ADDR_STATUS, 32'h0);
			check(rd[3], 32'(lim != 0));
			if (lim != 0) begin
				check(rd[8:4], 32'(lim));
				check(lock_fault, 1'b1);
			end
			lock_detect <= 1'b0;
			cyc(20);
		end
		apb(1'b1, ADDR_FAULT_CLEAR, 32'h0000_0004);
	endtask

	//==========================================================================
	// Closing, main sequence, watchdog
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		cyc(1);
		test_regs();
		test_volt(1'b0);
		test_volt(1'b1);
		test_latch();
		test_deglitch();
		test_retry();
		finish_test();
	end

	// Runs take about 6.4k cycles; over six times that means a hang
	initial begin
		repeat (40000) @(posedge ref_clk);
		mismatches++;
		finish_test();
	end
endmodule
